/* File: eic_cfg.svh */
// eic_cfg.svh: offsets, bit positions, reset values and counts of the
// external interrupt front end; assumes byte addressing on the bus.
`ifndef EIC_CFG_SVH
`define EIC_CFG_SVH
// register byte offsets
`define EIC_OFS_CTL 8'h88
`define EIC_OFS_REQ 8'hc0
`define EIC_OFS_POL 8'hc8
`define EIC_OFS_IEN0 8'h10
`define EIC_OFS_IEN1 8'h14
`define EIC_OFS_UHI 8'h18
`define EIC_OFS_ULO 8'h1c
`define EIC_OFS_UPOL 8'h20
`define EIC_OFS_SFLG 8'h30
`define EIC_OFS_SMSK 8'h40
`define EIC_OFS_STAT 8'h50
// control register bits
`define EIC_T1_OVF 7
`define EIC_T1_RUN 6
`define EIC_T0_OVF 5
`define EIC_T0_RUN 4
`define EIC_IRQ1_REQ 3
`define EIC_IRQ1_SENSE 2
`define EIC_IRQ0_REQ 1
`define EIC_IRQ0_SENSE 0
// polarity register bits
`define EIC_POL_B 6
`define EIC_POL_A 5
// enable register bits
`define EIC_GLB 7
`define EIC_IRQ1_EN 2
`define EIC_IRQ0_EN 0
// request register: interrupt 2 at this bit, 3..6 above it
`define EIC_IRC_BASE 1
`define EIC_RST_BYTE 8'h00
`define EIC_MC_CLKS 1
`define EIC_SRC_W 8
`endif

/* File: eic_core.sv */
// eic_core.sv: external interrupt front end with a classic Wishbone slave.
// assumes the cpu sequencer pulses ack when it enters a handler and
// peripheral sources share core_clk.
`timescale 1ns/1ps
`include "eic_cfg.svh"
module eic_core
  import eic_pkg::*;
#(
  parameter int SRC_W = `EIC_SRC_W,
  parameter int MC_CLKS = `EIC_MC_CLKS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // wishbone slave
  input wire eic_wbreq_s wbReq,
  output eic_wbrsp_s wbRsp,
  // pins
  input wire logic [7:0] user_io_pins,
  input wire logic dedicated_irq_pin_a,
  input wire logic dedicated_irq_pin_b,
  // peripheral sources: smart card, usb/rtc/keypad, i2c/fault/comparator
  input wire logic [SRC_W-1:0] scSrc,
  input wire logic [SRC_W-1:0] usbSrc,
  input wire logic [SRC_W-1:0] i2cSrc,
  // timers
  input wire logic [1:0] timerOvf,
  output logic [1:0] timerRun,
  // cpu sequencer
  input wire eic_irq_s irqAck,
  output eic_irq_s irqPend,
  input wire logic cpuStopped,
  output logic wakeReq
);
  localparam logic [7:0] SRC_MASK = 8'((9'h001 << SRC_W) - 9'h001);
  localparam logic [3:0] MC_LAST = 4'(MC_CLKS - 1);

  generate
    if (SRC_W < 1 || SRC_W > 8) begin : g_bad_src
      $error("SRC_W must be 1 to 8");
    end
    if (MC_CLKS < 1 || MC_CLKS > 16) begin : g_bad_mc
      $error("MC_CLKS must be 1 to 16");
    end
  endgenerate

  // group index of an address in a block of three words, 3 when outside
  function automatic logic [1:0] grpIdx(input logic [7:0] adr, input logic [7:0] base);
    logic [7:0] d;
    d = adr - base;
    if (adr >= base && d < 8'h0c && d[1:0] == 2'h0) begin
      grpIdx = d[3:2];
    end else begin
      grpIdx = 2'h3;
    end
  endfunction

  // edge pick of a dedicated pin; pos 1 takes the rising edge
  function automatic logic pickEdge(input logic rise, input logic fall, input logic pos);
    pickEdge = pos ? rise : fall;
  endfunction

  eic_state_s s;
  eic_state_s next_s;
  logic [9:0] pins;
  logic [7:0] userAct;
  logic [1:0] line;
  logic [1:0] lineFall;
  logic [1:0] pinRise;
  logic [1:0] pinFall;
  logic [1:0] pinEdge;
  logic [2:0][7:0] srcIn;
  logic [2:0] comb;
  logic [6:0] extFlags;
  logic [6:0] extEn;
  logic take;
  logic wr;
  logic rd;
  logic [1:0] fGrp;
  logic [1:0] mGrp;
  logic tick;

  // all pins cross into core_clk through three stages
  eic_sync #(
    .W(10)
  ) i_eic_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .din({dedicated_irq_pin_b, dedicated_irq_pin_a, user_io_pins}),
    .dout(pins)
  );

  // line derivation; internal lines are active high
  always_comb begin
    userAct = ~(pins[7:0] ^ s.uPol); // polarity 1 means pin high is active
    line[0] = |(userAct & s.uHi); // high priority events
    line[1] = |(userAct & s.uLo); // low priority events
    lineFall = line & ~s.linePrev; // activation seen as the rising edge of the active-high line
    pinRise = pins[9:8] & ~s.pinPrev;
    pinFall = ~pins[9:8] & s.pinPrev;
    pinEdge[0] = pickEdge(pinRise[0], pinFall[0], s.pol[`EIC_POL_A]);
    pinEdge[1] = pickEdge(pinRise[1], pinFall[1], s.pol[`EIC_POL_B]);
    srcIn[0] = 8'(scSrc) & SRC_MASK;
    srcIn[1] = 8'(usbSrc) & SRC_MASK;
    srcIn[2] = 8'(i2cSrc) & SRC_MASK;
    for (int k = 0; k < 3; k++) begin
      comb[k] = |(s.sFlag[k] & s.sMask[k]);
    end
    extFlags = {s.reqFlg[5:1], s.ctl[`EIC_IRQ1_REQ], s.ctl[`EIC_IRQ0_REQ]};
    extEn = {s.ien1[5:1], s.ien0[`EIC_IRQ1_EN], s.ien0[`EIC_IRQ0_EN]};
  end

  // bus decode; a request is taken in the cycle before ack rises
  always_comb begin
    take = wbReq.cyc && wbReq.stb && !s.ack;
    wr = take && wbReq.we && wbReq.sel[0];
    rd = take && !wbReq.we;
    fGrp = grpIdx(wbReq.adr, `EIC_OFS_SFLG);
    mGrp = grpIdx(wbReq.adr, `EIC_OFS_SMSK);
    tick = s.mcCnt == MC_LAST;
  end

  // next state: software write first, then service clears, then hardware
  // sets, so that an event in a clearing cycle is never lost
  always_comb begin
    next_s = s;
    next_s.ack = take;
    if (take) begin
      next_s.rdat = 16'h0000;
      case (wbReq.adr)
        `EIC_OFS_CTL: next_s.rdat[7:0] = s.ctl;
        `EIC_OFS_REQ: next_s.rdat[7:0] = s.reqFlg;
        `EIC_OFS_POL: next_s.rdat[7:0] = s.pol;
        `EIC_OFS_IEN0: next_s.rdat[7:0] = s.ien0;
        `EIC_OFS_IEN1: next_s.rdat[7:0] = s.ien1;
        `EIC_OFS_UHI: next_s.rdat[7:0] = s.uHi;
        `EIC_OFS_ULO: next_s.rdat[7:0] = s.uLo;
        `EIC_OFS_UPOL: next_s.rdat[7:0] = s.uPol;
        `EIC_OFS_STAT: next_s.rdat = {6'h00, s.wake, s.pend};
        default: begin
          if (fGrp != 2'h3) begin
            next_s.rdat[7:0] = s.sFlag[fGrp];
          end else if (mGrp != 2'h3) begin
            next_s.rdat[7:0] = s.sMask[mGrp];
          end
        end
      endcase
    end
    if (wr) begin
      case (wbReq.adr)
        `EIC_OFS_CTL: next_s.ctl = wbReq.dat[7:0];
        `EIC_OFS_REQ: next_s.reqFlg = wbReq.dat[7:0] & 8'h3e; // unused bits stay zero
        `EIC_OFS_POL: next_s.pol = wbReq.dat[7:0] & 8'h60;
        `EIC_OFS_IEN0: next_s.ien0 = wbReq.dat[7:0] & 8'h85;
        `EIC_OFS_IEN1: next_s.ien1 = wbReq.dat[7:0] & 8'h3e;
        `EIC_OFS_UHI: next_s.uHi = wbReq.dat[7:0];
        `EIC_OFS_ULO: next_s.uLo = wbReq.dat[7:0];
        `EIC_OFS_UPOL: next_s.uPol = wbReq.dat[7:0];
        default: begin
          if (mGrp != 2'h3) begin
            next_s.sMask[mGrp] = wbReq.dat[7:0] & SRC_MASK;
          end
        end
      endcase
    end
    // reading a source flag register empties it; software keeps the copy
    if (rd && fGrp != 2'h3) begin
      next_s.sFlag[fGrp] = 8'h00;
    end
    // handler entry clears the core flags without software
    if (irqAck.ext[0]) begin
      next_s.ctl[`EIC_IRQ0_REQ] = 1'b0;
    end
    if (irqAck.ext[1]) begin
      next_s.ctl[`EIC_IRQ1_REQ] = 1'b0;
    end
    if (irqAck.tmr[1]) begin
      next_s.ctl[`EIC_T1_OVF] = 1'b0;
    end
    if (irqAck.tmr[0]) begin
      next_s.ctl[`EIC_T0_OVF] = 1'b0;
    end
    for (int i = 2; i < 7; i++) begin
      if (irqAck.ext[i]) begin
        next_s.reqFlg[`EIC_IRC_BASE + i - 2] = 1'b0;
      end
    end
    // hardware sets, independent of any enable
    if (timerOvf[1]) begin
      next_s.ctl[`EIC_T1_OVF] = 1'b1;
    end
    if (timerOvf[0]) begin
      next_s.ctl[`EIC_T0_OVF] = 1'b1;
    end
    if (s.ctl[`EIC_IRQ0_SENSE]) begin
      if (lineFall[0]) begin
        next_s.ctl[`EIC_IRQ0_REQ] = 1'b1;
      end
    end else begin
      next_s.ctl[`EIC_IRQ0_REQ] = line[0]; // level mode is not latched
    end
    if (s.ctl[`EIC_IRQ1_SENSE]) begin
      if (lineFall[1]) begin
        next_s.ctl[`EIC_IRQ1_REQ] = 1'b1;
      end
    end else begin
      next_s.ctl[`EIC_IRQ1_REQ] = line[1];
    end
    if (pinEdge[0]) begin
      next_s.reqFlg[`EIC_IRC_BASE] = 1'b1;
    end
    if (pinEdge[1]) begin
      next_s.reqFlg[`EIC_IRC_BASE + 1] = 1'b1;
    end
    for (int k = 0; k < 3; k++) begin
      next_s.sFlag[k] = next_s.sFlag[k] | srcIn[k]; // set beats read clear
      next_s.grpPrev[k] = comb[k];
      if (comb[k] && !s.grpPrev[k]) begin
        next_s.reqFlg[`EIC_IRC_BASE + 2 + k] = 1'b1; // rising edge of the group
      end
    end
    next_s.linePrev = line;
    next_s.pinPrev = pins[9:8];
    // pending view refreshed once per machine cycle
    next_s.mcCnt = tick ? 4'h0 : s.mcCnt + 4'h1;
    if (tick) begin
      next_s.pend.ext = extFlags & extEn & {7{s.ien0[`EIC_GLB]}};
      next_s.pend.tmr = {s.ctl[`EIC_T1_OVF], s.ctl[`EIC_T0_OVF]} & {2{s.ien0[`EIC_GLB]}};
    end
    // wake runs from the synchronised level, needing no cpu clock activity
    next_s.wake = cpuStopped && line[0] && s.ien0[`EIC_IRQ0_EN];
  end

  // one register for all state; reset leaves every register at zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from state
  assign wbRsp.ack = s.ack;
  assign wbRsp.dat = {16'h0000, s.rdat};
  assign timerRun = {s.ctl[`EIC_T1_RUN], s.ctl[`EIC_T0_RUN]};
  assign irqPend = s.pend;
  assign wakeReq = s.wake;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // bus handshake: every take is answered next cycle, and only once
  ack_pulse_a: assert property (s.ack |=> !s.ack)
    else $error("ack held over two cycles");
  ack_take_a: assert property (take |=> wbRsp.ack)
    else $error("taken request not acknowledged");

  // irq0 and irq1 flags; writes are excluded from the level and service checks since software may set them
  irq0_edge_a: assert property (s.ctl[`EIC_IRQ0_SENSE] && lineFall[0] |=> s.ctl[`EIC_IRQ0_REQ])
    else $error("irq0 edge not flagged");
  irq1_edge_a: assert property (s.ctl[`EIC_IRQ1_SENSE] && lineFall[1] |=> s.ctl[`EIC_IRQ1_REQ])
    else $error("irq1 edge not flagged");
  irq0_level_a: assert property (!s.ctl[`EIC_IRQ0_SENSE] && !wr |=> s.ctl[`EIC_IRQ0_REQ] == $past(line[0]))
    else $error("irq0 level flag does not follow line");
  irq1_level_a: assert property (!s.ctl[`EIC_IRQ1_SENSE] && !wr |=> s.ctl[`EIC_IRQ1_REQ] == $past(line[1]))
    else $error("irq1 level flag does not follow line");
  irq0_service_a: assert property (s.ctl[`EIC_IRQ0_SENSE] && irqAck.ext[0] && !lineFall[0] && !wr
      |=> !s.ctl[`EIC_IRQ0_REQ])
    else $error("irq0 flag survived service");
  irq1_service_a: assert property (s.ctl[`EIC_IRQ1_SENSE] && irqAck.ext[1] && !lineFall[1] && !wr
      |=> !s.ctl[`EIC_IRQ1_REQ])
    else $error("irq1 flag survived service");

  // timer overflow flags: a set always wins over a service clear
  tmr_set_a: assert property (timerOvf[1] |=> s.ctl[`EIC_T1_OVF])
    else $error("timer1 overflow not flagged");
  tmr_clear_a: assert property (irqAck.tmr[0] && !timerOvf[0] && !wr |=> !s.ctl[`EIC_T0_OVF])
    else $error("timer0 flag survived service");

  // request register and dedicated pins
  ack_clear_a: assert property (irqAck.ext[2] && !pinEdge[0] |=> !s.reqFlg[`EIC_IRC_BASE])
    else $error("irq2 flag survived service");
  req_unused_a: assert property (s.reqFlg[0] == 1'b0 && s.reqFlg[7:6] == 2'b00)
    else $error("unused request bits set");
  pin_a_fall_a: assert property (!s.pol[`EIC_POL_A] && pinFall[0] |=> s.reqFlg[`EIC_IRC_BASE])
    else $error("pin a falling edge missed");
  pin_a_rise_a: assert property (s.pol[`EIC_POL_A] && pinRise[0] |=> s.reqFlg[`EIC_IRC_BASE])
    else $error("pin a rising edge missed");
  pin_b_pol_a: assert property (s.pol[`EIC_POL_B] && pinRise[1] |=> s.reqFlg[`EIC_IRC_BASE + 1])
    else $error("pin b rising edge missed");
  pin_b_fall_a: assert property (!s.pol[`EIC_POL_B] && pinFall[1] |=> s.reqFlg[`EIC_IRC_BASE + 1])
    else $error("pin b falling edge missed");

  // grouped peripheral sources
  read_clear_a: assert property (rd && fGrp == 2'h0 && srcIn[0] == 8'h00 |=> s.sFlag[0] == 8'h00)
    else $error("source flags not cleared by read");
  src_flag_a: assert property (|srcIn[1] |=> (s.sFlag[1] & $past(srcIn[1])) == $past(srcIn[1]))
    else $error("source flag not set");
  grp_edge_a: assert property (comb[0] && !s.grpPrev[0] |=> s.reqFlg[`EIC_IRC_BASE + 2])
    else $error("group 4 edge not flagged");
  grp5_edge_a: assert property (comb[1] && !s.grpPrev[1] |=> s.reqFlg[`EIC_IRC_BASE + 3])
    else $error("group 5 edge not flagged");
  grp6_edge_a: assert property (comb[2] && !s.grpPrev[2] |=> s.reqFlg[`EIC_IRC_BASE + 4])
    else $error("group 6 edge not flagged");

  // pending view and enables
  pend_gate_a: assert property (tick |=> s.pend.ext == $past(extFlags & extEn & {7{s.ien0[`EIC_GLB]}}))
    else $error("pending not gated by enables");
  glb_off_a: assert property (tick && !s.ien0[`EIC_GLB] |=> irqPend == '0)
    else $error("pending with global enable off");
  line_en_a: assert property (tick && !s.ien1[1] |=> !irqPend.ext[2])
    else $error("irq2 pending while disabled");

  // wake from stop
  wake_path_a: assert property (cpuStopped && line[0] && s.ien0[`EIC_IRQ0_EN] |=> wakeReq)
    else $error("wake not raised");
  wake_off_a: assert property (!cpuStopped |=> !wakeReq)
    else $error("wake raised while running");
endmodule

/* File: eic_cpu_model.sv */
// eic_cpu_model.sv: behavioural cpu interrupt sequencer facing the front end.
// assumes irqPend is registered and that irqAck is one cycle per handler entry.
`timescale 1ns/1ps
module eic_cpu_model
  import eic_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // sequencer side
  input wire eic_irq_s irqPend,
  input wire logic ackEn,
  output eic_irq_s irqAck
);
  // enter a handler for every pending line; one gap cycle follows each entry,
  // after which a level still shown pending in irqPend is taken a second time
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irqAck <= '0;
    end else begin
      irqAck <= (ackEn && irqAck == '0) ? irqPend : '0;
    end
  end
endmodule

/* File: eic_pkg.sv */
// eic_pkg.sv: types of the external interrupt front end.
// assumes eic_cfg.svh is compiled alongside.
package eic_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } eic_wbreq_s;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } eic_wbrsp_s;
  // timer overflow pair and the seven external lines
  typedef struct packed {
    logic [1:0] tmr;
    logic [6:0] ext;
  } eic_irq_s;
  typedef struct packed {
    logic ack;
    logic [15:0] rdat;
    logic [7:0] ctl;
    logic [7:0] reqFlg;
    logic [7:0] pol;
    logic [7:0] ien0;
    logic [7:0] ien1;
    logic [7:0] uHi;
    logic [7:0] uLo;
    logic [7:0] uPol;
    logic [2:0][7:0] sFlag;
    logic [2:0][7:0] sMask;
    logic [2:0] grpPrev;
    logic [1:0] linePrev;
    logic [1:0] pinPrev;
    logic [3:0] mcCnt;
    eic_irq_s pend;
    logic wake;
  } eic_state_s;
endpackage

/* File: eic_sync.sv */
// eic_sync.sv: three-stage input synchroniser with agreement filter.
// assumes asynchronous inputs; output follows once stages two and three agree.
`timescale 1ns/1ps
module eic_sync #(
  parameter int W = 10
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] stable;
  } eic_sync_s;
  eic_sync_s s;
  eic_sync_s next_s;

  // shift chain; ff1 feeds ff2 only, to keep metastability contained
  always_comb begin
    next_s = s;
    next_s.ff1 = din;
    next_s.ff2 = s.ff1;
    next_s.ff3 = s.ff2;
    for (int i = 0; i < W; i++) begin
      if (s.ff2[i] == s.ff3[i]) begin
        next_s.stable[i] = s.ff3[i];
      end
    end
  end

  // inputs idle high (active-low pins) but reset to zero; first edges settle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.stable;
endmodule

/* File: ext_interrupt_control_tb.sv */
// ext_interrupt_control_tb.sv: self-checking bench of the interrupt front end.
// assumes the one-cycle wishbone answer and 3-4 cycle pin synchroniser.
`timescale 1ns/1ps
module ext_interrupt_control_tb
  import eic_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  eic_wbreq_s wbReq = '0;
  eic_wbrsp_s wbRsp;
  logic [7:0] pins = 8'hff;
  logic pinA = 1'b0;
  logic pinB = 1'b0;
  logic [7:0] sc = '0;
  logic [7:0] usb = '0;
  logic [7:0] i2c = '0;
  logic [1:0] ovf = '0;
  logic [1:0] timerRun;
  eic_irq_s irqAck;
  eic_irq_s irqPend;
  logic stopped = 1'b0;
  logic wakeReq;
  logic ackEn = 1'b0;
  int err_count = 0;
  int n_checks = 0;

  always #2.5 core_clk = ~core_clk;

  eic_core i_eic_core (.core_clk(core_clk), .rst_n(rst_n), .wbReq(wbReq), .wbRsp(wbRsp),
    .user_io_pins(pins), .dedicated_irq_pin_a(pinA), .dedicated_irq_pin_b(pinB),
    .scSrc(sc), .usbSrc(usb), .i2cSrc(i2c), .timerOvf(ovf), .timerRun(timerRun),
    .irqAck(irqAck), .irqPend(irqPend), .cpuStopped(stopped), .wakeReq(wakeReq));
  eic_cpu_model i_eic_cpu_model (.core_clk(core_clk), .rst_n(rst_n), .irqPend(irqPend),
    .ackEn(ackEn), .irqAck(irqAck));

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle: hold the request until ack is sampled, then release
  task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h1, dat: {24'h0, d}};
    do begin
      @(posedge core_clk);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      $display("ERROR t=%0t no bus acknowledge", $time);
    end
    q = wbRsp.dat[7:0];
    wbReq <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask

  // pins pass a synchroniser, so give them a generous settle time
  task automatic settle();
    repeat (10) @(posedge core_clk);
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    settle();
    rd(8'h88, 8'h00);
    rd(8'hc0, 8'h00);
    rd(8'hc8, 8'h00);
    ovf <= 2'b11;
    @(posedge core_clk);
    ovf <= 2'b00;
    rd(8'h88, 8'ha0);
    wr(8'h88, 8'h50);
    chk({6'h0, timerRun}, 8'h03);
    wr(8'h88, 8'h00);
    rd(8'h88, 8'h00);
    $display("test reset and timer done");
    // irq0 edge from a high-priority user pin, then enables, wake, service
    wr(8'h18, 8'h01);
    wr(8'h88, 8'h01);
    pins[0] <= 1'b0;
    settle();
    rd(8'h88, 8'h03);
    wr(8'h10, 8'h01);
    settle();
    chk({7'h0, irqPend.ext[0]}, 8'h00);
    stopped <= 1'b1;
    settle();
    chk({7'h0, wakeReq}, 8'h01);
    stopped <= 1'b0;
    ackEn <= 1'b1;
    wr(8'h10, 8'h81);
    settle();
    rd(8'h88, 8'h01);
    ackEn <= 1'b0;
    pins[0] <= 1'b1;
    wr(8'h10, 8'h00);
    $display("test irq0 done");
    // irq1 from a low-priority user pin: level follows, edge latches
    wr(8'h1c, 8'h02);
    wr(8'h88, 8'h00);
    pins[1] <= 1'b0;
    settle();
    rd(8'h88, 8'h08);
    pins[1] <= 1'b1;
    settle();
    rd(8'h88, 8'h00);
    wr(8'h88, 8'h04);
    pins[1] <= 1'b0;
    settle();
    pins[1] <= 1'b1;
    settle();
    rd(8'h88, 8'h0c);
    $display("test irq1 done");
    // dedicated pins on rising edges
    wr(8'hc8, 8'h60);
    rd(8'hc8, 8'h60);
    pinA <= 1'b1;
    settle();
    rd(8'hc0, 8'h02);
    pinB <= 1'b1;
    settle();
    rd(8'hc0, 8'h06);
    wr(8'hc0, 8'h00);
    $display("test dedicated pins done");
    // grouped peripheral sources: one-cycle pulses become request edges
    wr(8'h40, 8'h01);
    wr(8'h44, 8'h01);
    wr(8'h48, 8'h01);
    sc[0] <= 1'b1;
    usb[0] <= 1'b1;
    i2c[0] <= 1'b1;
    @(posedge core_clk);
    sc[0] <= 1'b0;
    usb[0] <= 1'b0;
    i2c[0] <= 1'b0;
    rd(8'hc0, 8'h38);
    rd(8'h30, 8'h01);
    rd(8'h30, 8'h00);
    rd(8'h34, 8'h01);
    $display("test grouped sources done");
    // falling pin edges, service through the cpu model, timer service
    wr(8'hc0, 8'h00);
    wr(8'hc8, 8'h00);
    wr(8'h14, 8'h02);
    wr(8'h10, 8'h80);
    pinA <= 1'b0;
    pinB <= 1'b0;
    settle();
    rd(8'hc0, 8'h06);
    rd(8'h50, 8'h04);
    ackEn <= 1'b1;
    settle();
    rd(8'hc0, 8'h04);
    ovf <= 2'b10;
    @(posedge core_clk);
    ovf <= 2'b00;
    settle();
    rd(8'h88, 8'h0c);
    ackEn <= 1'b0;
    $display("test service done");
    summarize();
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    summarize();
  end
endmodule
